// ==== common/ptc_pkg.sv ====
// Shared types and constants for the parallel transmit capture block
`default_nettype none

package ptc_pkg;

  // ==========================================================================
  // Widths
  localparam int PTC_PIN_W = 8;
  localparam int PTC_NIB_W = 4;
  localparam int PTC_DATA_W = 10;
  localparam int PTC_GPIO_W = 4;

  // ==========================================================================
  // Field positions inside the captured word and on the data pins
  localparam int PTC_LO_NIB_LSB = 0;
  localparam int PTC_HI_NIB_LSB = 4;
  localparam int PTC_TBI_EN_BIT = 8;
  localparam int PTC_TBI_ER_BIT = 9;
  localparam int PTC_RTBI_LO_CTL_BIT = 4;
  localparam int PTC_RTBI_HI_NIB_LSB = 5;
  localparam int PTC_RTBI_HI_CTL_BIT = 9;
  localparam int PTC_GPIO_PIN_LSB = 4;

  // ==========================================================================
  // Transmit clock rates the link side runs at, in kHz
  localparam int PTC_GTX_1000_KHZ = 125000;
  localparam int PTC_TXCLK_100_KHZ = 25000;
  localparam int PTC_TXCLK_10_KHZ = 2500;

  // ==========================================================================
  // Interface modes
  typedef enum logic [6:0] {
    PTC_MODE_MII = 7'h01,
    PTC_MODE_GMII = 7'h02,
    PTC_MODE_RGMII10 = 7'h04,
    PTC_MODE_RGMII100 = 7'h08,
    PTC_MODE_RGMII1000 = 7'h10,
    PTC_MODE_TBI = 7'h20,
    PTC_MODE_RTBI = 7'h40
  } ptc_mode_e;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [PTC_PIN_W-1:0] txd;
    logic en;
    logic er;
  } ptc_pins_s;

  typedef struct packed {
    logic [PTC_DATA_W-1:0] data;
    logic en;
    logic er;
  } ptc_word_s;

  typedef struct packed {
    logic [PTC_NIB_W-1:0] nib;
    logic ctl;
  } ptc_fall_s;

  // ==========================================================================
  // Reset values
  localparam ptc_mode_e PTC_MODE_RST = PTC_MODE_MII;
  localparam ptc_pins_s PTC_PINS_RST = 10'h000;
  localparam ptc_word_s PTC_WORD_RST = 12'h000;
  localparam ptc_fall_s PTC_FALL_RST = 5'h00;
  localparam logic [PTC_GPIO_W-1:0] PTC_GPIO_RST = 4'h0;

endpackage : ptc_pkg

`default_nettype wire

// ==== hw/ptc_sync.sv ====
// Two-stage synchroniser for levels entering a clock domain
`default_nettype none
`timescale 1ns/1ps

module ptc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // ==========================================================================
  // Stages
  // No reset: the stages settle in two edges and carry no control state
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = d;
    sync_d = meta_q;
  end

  always_ff @(posedge clk) begin
    meta_q <= meta_d;
    q <= sync_d;
  end

endmodule : ptc_sync

`default_nettype wire

// ==== hw/ptc_capture.sv ====
// Transmit-side capture of a parallel Ethernet media interface
`default_nettype none
`timescale 1ns/1ps

// Behaviour
// - In MII, RGMII-10 and RGMII-100 the low data nibble is taken on each rising transmit clock edge.
// - In MII, RGMII and RTBI the upper four data pins are not data and are handed out as general-purpose inputs 0 to 3.
// - In RGMII-1000 bits 3..0 come on the rising edge and bits 7..4 on the next falling edge, in that order from the MAC.
// - In TBI a ten-bit group is taken on each rising edge: data pins to bits 7..0, enable to bit 8, error to bit 9.
// - In RTBI the rising edge gives bits 3..0 from the low nibble and bit 4 from the enable pin.
// - In RTBI the falling edge gives bits 8..5 from the low nibble and bit 9 from the enable pin, closing the group.
// - In MII and GMII the transmit enable is sampled on the rising edge of the active transmit clock.
// - In every RGMII mode the control pin is sampled on both the rising and the falling edge.
// - In MII and GMII the transmit error is sampled on the same rising edge as the data.
// - In RGMII and RTBI the transmit error pin is ignored; RGMII errors travel on the control signal.
// - In GMII all eight data bits are taken on each rising edge of the gigabit clock.
// - In MII the data is clocked by the MII transmit clock at 25 or 2.5 MHz.
module ptc_capture (
  input wire logic clk,
  input wire logic rst,
  input wire ptc_pkg::ptc_mode_e mode,
  input wire logic tx_clk,
  input wire ptc_pkg::ptc_pins_s tx_pins,
  output ptc_pkg::ptc_word_s tx_word,
  output logic tx_valid,
  output logic gpio_release,
  output logic [ptc_pkg::PTC_GPIO_W-1:0] gpio_in
);
  import ptc_pkg::*;

  // ==========================================================================
  // Mode decoding

  // Modes with a four-bit data path free the upper data pins
  function automatic logic nibble_path(input ptc_mode_e m);
    case (m)
      PTC_MODE_MII,
      PTC_MODE_RGMII10,
      PTC_MODE_RGMII100,
      PTC_MODE_RGMII1000,
      PTC_MODE_RTBI: begin
        nibble_path = 1'b1;
      end
      default: begin
        nibble_path = 1'b0;
      end
    endcase
  endfunction : nibble_path

  // RGMII error: the control level changes between the two halves
  function automatic logic rgmii_err(input logic rise_ctl,
                                     input logic fall_ctl);
    rgmii_err = rise_ctl ^ fall_ctl;
  endfunction : rgmii_err

  // Builds one delivered word from the rising sample and the falling half
  function automatic ptc_word_s assemble(input ptc_mode_e m,
                                          input ptc_pins_s rise,
                                          input ptc_fall_s fall);
    ptc_word_s w;
    w = PTC_WORD_RST;
    case (m)
      PTC_MODE_MII: begin
        w.data[PTC_LO_NIB_LSB +: PTC_NIB_W] =
          rise.txd[PTC_LO_NIB_LSB +: PTC_NIB_W];
        w.en = rise.en;
        w.er = rise.er;
      end
      PTC_MODE_GMII: begin
        w.data[PTC_PIN_W-1:0] = rise.txd;
        w.en = rise.en;
        w.er = rise.er;
      end
      PTC_MODE_RGMII10,
      PTC_MODE_RGMII100: begin
        // Same nibble is repeated on the falling edge, so only one is kept
        w.data[PTC_LO_NIB_LSB +: PTC_NIB_W] =
          rise.txd[PTC_LO_NIB_LSB +: PTC_NIB_W];
        w.en = rise.en;
        w.er = rgmii_err(rise.en, fall.ctl);
      end
      PTC_MODE_RGMII1000: begin
        w.data[PTC_LO_NIB_LSB +: PTC_NIB_W] =
          rise.txd[PTC_LO_NIB_LSB +: PTC_NIB_W];
        w.data[PTC_HI_NIB_LSB +: PTC_NIB_W] = fall.nib;
        w.en = rise.en;
        w.er = rgmii_err(rise.en, fall.ctl);
      end
      PTC_MODE_TBI: begin
        w.data[PTC_PIN_W-1:0] = rise.txd;
        w.data[PTC_TBI_EN_BIT] = rise.en;
        w.data[PTC_TBI_ER_BIT] = rise.er;
      end
      PTC_MODE_RTBI: begin
        w.data[PTC_LO_NIB_LSB +: PTC_NIB_W] =
          rise.txd[PTC_LO_NIB_LSB +: PTC_NIB_W];
        w.data[PTC_RTBI_LO_CTL_BIT] = rise.en;
        w.data[PTC_RTBI_HI_NIB_LSB +: PTC_NIB_W] = fall.nib;
        w.data[PTC_RTBI_HI_CTL_BIT] = fall.ctl;
      end
      default: begin
        // A code that is not one-hot delivers idle words
        w = PTC_WORD_RST;
      end
    endcase
    assemble = w;
  endfunction : assemble

  // ==========================================================================
  // System clock side: mode register and released pins
  ptc_mode_e mode_q;
  ptc_mode_e mode_d;
  logic release_q;
  logic release_d;

  // Mode is taken only while in reset and then held, so the multi-bit
  // crossing into the link domain never sees it move while words flow
  always_comb begin
    mode_d = mode_q;
    // Released pins follow the held mode from the first edge after reset
    release_d = nibble_path(mode_q);
    if (rst) begin
      mode_d = mode;
      release_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    mode_q <= mode_d;
    release_q <= release_d;
  end

  assign gpio_release = release_q;

  // ==========================================================================
  // General-purpose side of the upper data pins
  // Limitation: gpio_in lags the pins by two to three system clocks
  logic [PTC_GPIO_W-1:0] gpio_q;
  logic [PTC_GPIO_W-1:0] gpio_d;
  logic [PTC_GPIO_W-1:0] gpio_sync;

  // Upper pins come from the link side and must be retimed first
  ptc_sync #(
    .W(PTC_GPIO_W)
  ) u_gpio_sync (
    .clk(clk),
    .d(tx_pins.txd[PTC_GPIO_PIN_LSB +: PTC_GPIO_W]),
    .q(gpio_sync)
  );

  always_comb begin
    // Pins still carrying data read as zero on the general-purpose side
    gpio_d = release_q ? gpio_sync : PTC_GPIO_RST;
    if (rst) begin
      gpio_d = PTC_GPIO_RST;
    end
  end

  always_ff @(posedge clk) begin
    gpio_q <= gpio_d;
  end

  assign gpio_in = gpio_q;

  // ==========================================================================
  // Crossings into the transmit clock domain
  // Mode only moves in reset, and the link stays in reset two edges longer
  logic [6:0] mode_tx_raw;
  ptc_mode_e mode_tx;
  logic lrst;

  ptc_sync #(
    .W(7)
  ) u_mode_sync (
    .clk(tx_clk),
    .d(mode_q),
    .q(mode_tx_raw)
  );

  // Reset reaches the link side only while the transmit clock runs
  ptc_sync #(
    .W(1)
  ) u_rst_sync (
    .clk(tx_clk),
    .d(rst),
    .q(lrst)
  );

  always_comb begin
    mode_tx = ptc_mode_e'(mode_tx_raw);
  end

  // ==========================================================================
  // Falling edge: second half of each double-rate transfer
  // Taken in every mode; the single-rate modes simply ignore it
  ptc_fall_s fall_q;
  ptc_fall_s fall_d;

  always_comb begin
    fall_d.nib = tx_pins.txd[PTC_LO_NIB_LSB +: PTC_NIB_W];
    fall_d.ctl = tx_pins.en;
    if (lrst) begin
      fall_d = PTC_FALL_RST;
    end
  end

  always_ff @(negedge tx_clk) begin
    fall_q <= fall_d;
  end

  // ==========================================================================
  // Link start-up
  // The first rising edge out of reset has no earlier sample to pair with,
  // so delivery waits one period rather than hand out a half-built word
  typedef enum logic [2:0] {
    PTC_LINK_IDLE = 3'h1,
    PTC_LINK_FILL = 3'h2,
    PTC_LINK_RUN = 3'h4
  } ptc_link_e;

  ptc_link_e link_q;
  ptc_link_e link_d;

  always_comb begin
    case (link_q)
      PTC_LINK_IDLE: begin
        // First edge out of reset loads only the rising sample
        link_d = PTC_LINK_FILL;
      end
      PTC_LINK_FILL: begin
        // The falling half of that sample has now arrived
        link_d = PTC_LINK_RUN;
      end
      PTC_LINK_RUN: begin
        // Free-running delivery, one word per period
        link_d = PTC_LINK_RUN;
      end
      default: begin
        // An illegal code drops back to idle
        link_d = PTC_LINK_IDLE;
      end
    endcase
    if (lrst) begin
      link_d = PTC_LINK_IDLE;
    end
  end

  always_ff @(posedge tx_clk) begin
    link_q <= link_d;
  end

  // ==========================================================================
  // Rising edge: first half, then delivery one period later
  // Rising sample waits a period so that its falling partner has arrived
  ptc_pins_s rise_q;
  ptc_pins_s rise_d;

  always_comb begin
    rise_d = tx_pins;
    if (lrst) begin
      rise_d = PTC_PINS_RST;
    end
  end

  always_ff @(posedge tx_clk) begin
    rise_q <= rise_d;
  end

  // ==========================================================================
  // Delivery of finished words
  // Words read as zero whenever they are not valid, so nothing stale leaks
  ptc_word_s word_q;
  ptc_word_s word_d;
  logic valid_q;
  logic valid_d;

  always_comb begin
    // Both halves of the word are real once the link has left idle
    valid_d = (link_q == PTC_LINK_FILL) ||
      (link_q == PTC_LINK_RUN);
    word_d = PTC_WORD_RST;
    if (valid_d) begin
      word_d = assemble(mode_tx, rise_q, fall_q);
    end
    if (lrst) begin
      word_d = PTC_WORD_RST;
      valid_d = 1'b0;
    end
  end

  always_ff @(posedge tx_clk) begin
    word_q <= word_d;
    valid_q <= valid_d;
  end

  assign tx_word = word_q;
  assign tx_valid = valid_q;

endmodule : ptc_capture

`default_nettype wire

// ==== sim/ptc_capture_assertions.sv ====
// Checker for the transmit capture block
`default_nettype none
`timescale 1ns/1ps
module ptc_capture_assertions (
  input wire logic clk,
  input wire logic rst,
  input wire ptc_pkg::ptc_mode_e mode,
  input wire logic tx_clk,
  input wire ptc_pkg::ptc_pins_s tx_pins,
  input wire ptc_pkg::ptc_word_s tx_word,
  input wire logic tx_valid,
  input wire logic gpio_release,
  input wire logic [ptc_pkg::PTC_GPIO_W-1:0] gpio_in
);
  import ptc_pkg::*;
  // ======
  // Link samples; reset reaches the link late, so words count after 7 edges
  ptc_pins_s r_q;
  ptc_fall_s f_q;
  logic [2:0] run_q;
  logic ok;
  assign ok = run_q == 3'h7;
  always_ff @(posedge tx_clk) begin
    r_q <= tx_pins;
    run_q <= rst ? 3'h0 : run_q + {2'h0, run_q != 3'h7};
  end
  always_ff @(negedge tx_clk) begin
    f_q <= {tx_pins.txd[3:0], tx_pins.en};
  end
  // ======
  property p_mii;
    @(posedge tx_clk) disable iff (rst) ok && mode == PTC_MODE_MII |->
      tx_word == {6'h00, $past(r_q.txd[3:0]), $past(r_q.en), $past(r_q.er)};
  endproperty
  a_mii: assert property (p_mii)
    else $error("mii word wrong");
  property p_gmii;
    @(posedge tx_clk) disable iff (rst) ok && mode == PTC_MODE_GMII |->
      tx_word == {2'h0, $past(r_q.txd), $past(r_q.en), $past(r_q.er)};
  endproperty
  a_gmii: assert property (p_gmii)
    else $error("gmii word wrong");
  property p_rglo;
    @(posedge tx_clk) disable iff (rst)
      ok && mode inside {PTC_MODE_RGMII10, PTC_MODE_RGMII100} |->
      tx_word == {6'h00, $past(r_q.txd[3:0]), $past(r_q.en),
                  $past(r_q.en ^ f_q.ctl)};
  endproperty
  a_rglo: assert property (p_rglo)
    else $error("slow ddr word wrong");
  property p_rg1000;
    @(posedge tx_clk) disable iff (rst) ok && mode == PTC_MODE_RGMII1000 |->
      tx_word == {2'h0, $past(f_q.nib), $past(r_q.txd[3:0]), $past(r_q.en),
                  $past(r_q.en ^ f_q.ctl)};
  endproperty
  a_rg1000: assert property (p_rg1000)
    else $error("fast ddr word wrong");
  property p_tbi;
    @(posedge tx_clk) disable iff (rst) ok && mode == PTC_MODE_TBI |->
      tx_word == {$past(r_q.er), $past(r_q.en), $past(r_q.txd), 2'h0};
  endproperty
  a_tbi: assert property (p_tbi)
    else $error("ten bit group wrong");
  property p_rtbi;
    @(posedge tx_clk) disable iff (rst) ok && mode == PTC_MODE_RTBI |->
      tx_word == {$past(f_q.ctl), $past(f_q.nib), $past(r_q.en),
                  $past(r_q.txd[3:0]), 2'h0};
  endproperty
  a_rtbi: assert property (p_rtbi)
    else $error("ddr ten bit group wrong");
  property p_valid;
    @(posedge tx_clk) disable iff (rst) run_q >= 3'h5 |-> tx_valid;
  endproperty
  a_valid: assert property (p_valid)
    else $error("word not delivered");
  property p_rel;
    @(posedge clk) disable iff (rst) !$past(rst) |->
      gpio_release == ((mode & 7'h5D) != 7'h00);
  endproperty
  a_rel: assert property (p_rel)
    else $error("upper pins release wrong");
  property p_gz;
    @(posedge clk) disable iff (rst) !gpio_release |-> gpio_in == 4'h0;
  endproperty
  a_gz: assert property (p_gz)
    else $error("pins seen while kept as data");
  c_rg: cover property (@(posedge tx_clk) ok && mode == PTC_MODE_RGMII1000);
  c_rtbi: cover property (@(posedge tx_clk) ok && mode == PTC_MODE_RTBI);
  c_rel: cover property (@(posedge clk) $rose(gpio_release));
endmodule : ptc_capture_assertions
`default_nettype wire

// ==== sim/ptc_mac_model.sv ====
// Transmit side of a MAC driving the parallel pins
`default_nettype none
`timescale 1ns/1ps
module ptc_mac_model (
  input wire logic hold,
  input wire logic [3:0] hi,
  output logic tx_clk,
  output ptc_pkg::ptc_pins_s tx_pins
);
  import ptc_pkg::*;
  integer seed = 32'h3d727e58;
  logic [31:0] v;
  // ======
  // Free-running clock; every pin not held at hi changes mid half period, so a stale
  // value is never mistaken for a fresh one
  initial begin
    tx_clk = 1'b0;
    tx_pins = PTC_PINS_RST;
  end
  // Low nibble before rising edge, high nibble before falling edge
  always begin
    #31.25;
    v = $random(seed);
    tx_pins = {hold ? hi : v[13:10], v[3:0], v[4], v[5]};
    #31.25;
    tx_clk = !tx_clk;
  end
endmodule : ptc_mac_model
`default_nettype wire

// ==== sim/tb_ptc_capture.sv ====
// Regression top for the transmit capture block
`default_nettype none
`timescale 1ns/1ps
module tb_ptc_capture;
  import ptc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  ptc_mode_e mode = PTC_MODE_MII;
  logic [3:0] hi = 4'h0;
  logic hold = 1'b0;
  logic chk = 1'b0;
  logic tx_clk;
  logic tx_valid;
  logic gpio_release;
  logic [3:0] gpio_in;
  ptc_pins_s tx_pins, r;
  ptc_fall_s f;
  ptc_word_s tx_word;
  ptc_word_s exp_q[$];
  ptc_word_s exp_w;
  integer seed = 32'h3d727e58;
  integer miscompares = 0;
  integer checks_done = 0;
  always #50 clk = !clk;
  ptc_mac_model ptc_mac_model_inst (.hold(hold), .hi(hi), .tx_clk(tx_clk),
    .tx_pins(tx_pins));
  ptc_capture ptc_capture_inst (.clk(clk), .rst(rst), .mode(mode),
    .tx_clk(tx_clk), .tx_pins(tx_pins), .tx_word(tx_word),
    .tx_valid(tx_valid), .gpio_release(gpio_release), .gpio_in(gpio_in));
  // ======
  // Reference words built from the pins seen at both edges
  function automatic ptc_word_s ref_word(ptc_mode_e m, ptc_pins_s a,
                                         ptc_fall_s b);
    ref_word = PTC_WORD_RST;
    case (m)
      PTC_MODE_MII: ref_word = {6'h00, a.txd[3:0], a.en, a.er};
      PTC_MODE_GMII: ref_word = {2'h0, a.txd, a.en, a.er};
      PTC_MODE_RGMII10,
      PTC_MODE_RGMII100: ref_word = {6'h00, a.txd[3:0], a.en, a.en ^ b.ctl};
      PTC_MODE_RGMII1000:
        ref_word = {2'h0, b.nib, a.txd[3:0], a.en, a.en ^ b.ctl};
      PTC_MODE_TBI: ref_word = {a.er, a.en, a.txd, 2'h0};
      PTC_MODE_RTBI:
        ref_word = {b.ctl, b.nib, a.en, a.txd[3:0], 2'h0};
      default: ;
    endcase
  endfunction : ref_word
  task automatic check(input string what, input logic [11:0] seen,
                       input logic [11:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Each word is queued once its falling half is seen, due one edge later
  always @(posedge tx_clk) begin
    #1;
    if (exp_q.size() > 0) begin
      exp_w = exp_q.pop_front();
      if (chk) begin
        check("word", tx_word, exp_w);
        check("valid", {11'h000, tx_valid}, 12'h001);
      end
    end
    r = tx_pins;
  end
  always @(negedge tx_clk) begin
    #1;
    f = {tx_pins.txd[3:0], tx_pins.en};
    exp_q.push_back(ref_word(mode, r, f));
  end
  // ======
  // Mode may only change in reset, so every pass starts with one
  task automatic run(input ptc_mode_e m);
    @(posedge clk);
    rst <= 1'b1;
    mode <= m;
    hi <= 4'($random(seed));
    hold <= (m & 7'h5D) != 7'h00;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (12) @(posedge clk);
    chk <= 1'b1;
    repeat (40) @(posedge clk);
    chk <= 1'b0;
    #1;
    check("release", {11'h000, gpio_release}, {11'h000, hold});
    check("gpio", {8'h00, gpio_in}, hold ? {8'h00, hi} : 12'h000);
    $display("test done for mode %h", m);
  endtask : run
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim
  initial begin
    // The last pass shifts out to the illegal all-zero mode
    for (int i = 0; i < 8; i++) begin
      run(ptc_mode_e'(7'h01 << i));
    end
    end_sim();
  end
  // Eight passes take about 47 us; allow four times that
  initial begin
    #200000;
    miscompares = miscompares + 1;
    end_sim();
  end
endmodule : tb_ptc_capture
bind ptc_capture ptc_capture_assertions ptc_capture_assertions_inst (
  .clk(clk), .rst(rst), .mode(mode), .tx_clk(tx_clk), .tx_pins(tx_pins),
  .tx_word(tx_word), .tx_valid(tx_valid), .gpio_release(gpio_release),
  .gpio_in(gpio_in));
`default_nettype wire
